// [logic/ssl_link.sv]
// top of the synchronous serial dma link: control, dma channel, registers
//
// Contract
// - synchronous mode, 100-byte blocks each way
// - sender makes clock, receiver never drives it
// - request line, then clock/data after 100 us
// - slave send request, slave clocks data later
// - tx register empty triggers one dma byte
// - rx register full triggers one dma store
// - byte transfers, memory address increments
// - tx reads table, rx writes table
// - clock pin output on tx, input on rx
// - synchronous mode, bit rate from system clock
// - enable tx/empty or rx/full events; code masks only done, error and send request events
// - clearing empty/full flag starts operation
// - irq zero raises, switches to receive
// - dma count end sets done flag
// - tx error flag: 0 normal, 1 error
// - rx error flag: 0 normal, 1 abnormal
// - first byte direct, dma count 99
`timescale 1ns/1ps
module ssl_link #(
    parameter int REQ_DELAY = ssl_pkg::REQ_DELAY_CYC,
    parameter int AW        = 8
) (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       sck_i,
    output logic            sck_o,
    output logic            sck_oe_o,
    output logic            txd_o,
    input  wire logic       rxd_i,
    output logic            receive_request_out_o,
    input  wire logic       send_request_in_i,
    output logic            irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    // state and registers
    ssl_pkg::ssl_state_e state_q, state_d;
    logic [7:0]              bitrate_q;
    logic [7:0]              brg_q;
    logic [ssl_pkg::ST_W-1:0] status_q, mask_q;
    logic [7:0]              tx_data_reg_q;
    logic                    tx_reg_empty_flag_q;
    logic                    rx_reg_full_flag_q;
    logic [7:0]              rx_data_reg_q;
    logic [7:0]              dma_transfer_count_q;
    logic [AW-1:0]           dma_memory_address_q;
    logic [AW-1:0]           tbl_addr_q;
    logic [31:0]             wait_q;
    logic                    dma_fetch_q;
    logic                    srq_q;
    logic                    rrq_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire wr_ctrl  = reg_wr_i && reg_addr_i == ssl_pkg::OFF_CTRL;
    wire wr_stat  = reg_wr_i && reg_addr_i == ssl_pkg::OFF_STATUS;
    wire wr_mask  = reg_wr_i && reg_addr_i == ssl_pkg::OFF_MASK;
    wire wr_txd   = reg_wr_i && reg_addr_i == ssl_pkg::OFF_TXDATA;
    wire wr_brr   = reg_wr_i && reg_addr_i == ssl_pkg::OFF_BITRATE;
    wire wr_maddr = reg_wr_i && reg_addr_i == ssl_pkg::OFF_MEMADDR;
    wire wr_table = reg_wr_i && reg_addr_i == ssl_pkg::OFF_TABLE;
    wire tx_start = wr_ctrl && reg_wdata_i[ssl_pkg::CTL_TX_START];
    wire rx_arm   = wr_ctrl && reg_wdata_i[ssl_pkg::CTL_RX_ARM];
    wire abort    = wr_ctrl && reg_wdata_i[ssl_pkg::CTL_ABORT];
    wire srq_rise = send_request_in_i && !srq_q;
    wire tx_mode  = state_q == ssl_pkg::ST_TX_RUN;
    wire rx_mode  = state_q == ssl_pkg::ST_RX_RUN;
    wire busy     = state_q != ssl_pkg::ST_IDLE;
    wire rx_busy  = state_q == ssl_pkg::ST_RX_RUN || state_q == ssl_pkg::ST_RX_WAIT;
    wire wait_end = wait_q == 32'd0;
    wire bit_en   = brg_q == 8'h00; // bit rate from system clock

    ////////////////////////////////////////////////////////////////////////////
    // shifter and table
    logic       load;
    logic       sh_busy, sh_done;
    logic [7:0] sh_rx;
    logic [7:0] tbl_rdata;
    logic       sck_int;
    logic       txd_int;

    assign load = tx_mode && !tx_reg_empty_flag_q && !sh_busy;

    ssl_shifter u_shift (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .bit_en_i    (bit_en),
        .tx_mode_i   (tx_mode),
        .rx_mode_i   (rx_mode),
        .load_i      (load),
        .load_data_i (tx_data_reg_q),
        .sck_i       (sck_i),
        .rxd_i       (rxd_i),
        .sck_o       (sck_int),
        .txd_o       (txd_int),
        .busy_o      (sh_busy),
        .byte_done_o (sh_done),
        .rx_byte_o   (sh_rx)
    );

    // rx dma store: full flag writes byte to next table slot
    wire rx_store = rx_mode && rx_reg_full_flag_q;
    // tx dma fetch: empty flag requests next table byte
    wire tx_dma   = tx_mode && tx_reg_empty_flag_q && !dma_fetch_q
                    && dma_transfer_count_q != 8'h00;
    wire last_tx  = tx_mode && sh_done && dma_transfer_count_q == 8'h00
                    && tx_reg_empty_flag_q;
    wire last_rx  = rx_store && dma_transfer_count_q == 8'h00;

    wire [AW-1:0] ram_addr = rx_store ? tbl_addr_q : dma_memory_address_q;

    ssl_table_ram #(
        .DEPTH (1 << AW),
        .AW    (AW)
    ) u_ram (
        .clock_i (clock_i),
        .we_i    (rx_store || wr_table),
        .waddr_i (rx_store ? dma_memory_address_q : tbl_addr_q),
        .wdata_i (rx_store ? rx_data_reg_q : reg_wdata_i),
        .raddr_i (ram_addr),
        .rdata_o (tbl_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ssl_pkg::ST_IDLE:
                if (srq_rise)
                    state_d = ssl_pkg::ST_RX_WAIT;
                else if (tx_start)
                    state_d = ssl_pkg::ST_TX_WAIT;
            ssl_pkg::ST_TX_WAIT:
                if (wait_end)
                    state_d = ssl_pkg::ST_TX_RUN;
            ssl_pkg::ST_TX_RUN:
                if (last_tx || abort)
                    state_d = ssl_pkg::ST_IDLE;
            ssl_pkg::ST_RX_WAIT:
                if (abort)
                    state_d = ssl_pkg::ST_IDLE;
                else if (rx_arm)
                    state_d = ssl_pkg::ST_RX_RUN;
            ssl_pkg::ST_RX_RUN:
                if (last_rx || abort)
                    state_d = ssl_pkg::ST_IDLE;
            default:
                state_d = ssl_pkg::ST_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // events
    logic [ssl_pkg::ST_W-1:0] ev;
    always_comb
    begin
        ev = '0;
        ev[ssl_pkg::ST_TX_DONE]  = last_tx;
        ev[ssl_pkg::ST_RX_DONE]  = last_rx;
        // a start that meets an incoming send request is refused too
        ev[ssl_pkg::ST_TX_ERR]   = (tx_start && (busy || srq_rise))
                                   || (abort && tx_mode);
        ev[ssl_pkg::ST_RX_ERR]   = (abort && rx_busy) || (rx_mode && sh_done
                                   && rx_reg_full_flag_q);
        ev[ssl_pkg::ST_EXT_EXTERNAL_IRQ_ZERO] = srq_rise;
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequential
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            state_q              <= ssl_pkg::ST_IDLE;
            bitrate_q            <= ssl_pkg::BITRATE_RST;
            brg_q                <= 8'h00;
            status_q             <= '0;
            mask_q               <= ssl_pkg::MASK_RST;
            tx_data_reg_q        <= 8'h00;
            tx_reg_empty_flag_q  <= 1'b1;
            rx_reg_full_flag_q   <= 1'b0;
            rx_data_reg_q        <= 8'h00;
            dma_transfer_count_q <= 8'h00;
            dma_memory_address_q <= '0;
            tbl_addr_q           <= '0;
            wait_q               <= 32'd0;
            dma_fetch_q          <= 1'b0;
            srq_q                <= 1'b0;
            rrq_q                <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            srq_q   <= send_request_in_i;
            brg_q   <= bit_en ? bitrate_q : brg_q - 8'h01;
            status_q <= (status_q & ~(wr_stat ? reg_wdata_i[ssl_pkg::ST_W-1:0] : '0)) | ev;
            if (wr_mask)
                mask_q <= reg_wdata_i[ssl_pkg::ST_W-1:0];
            if (wr_brr)
                bitrate_q <= reg_wdata_i;
            if (wr_maddr)
                dma_memory_address_q <= reg_wdata_i[AW-1:0];
            if (wr_table)
                tbl_addr_q <= tbl_addr_q + 1'b1;
            else if (reg_wr_i && reg_addr_i == ssl_pkg::OFF_COUNT)
                tbl_addr_q <= reg_wdata_i[AW-1:0];
            // first byte written directly, dma counts the rest
            if (state_q == ssl_pkg::ST_IDLE && tx_start && !srq_rise)
            begin
                wait_q               <= REQ_DELAY - 1;
                rrq_q                <= 1'b0;
                dma_transfer_count_q <= 8'(ssl_pkg::DMA_COUNT);
            end
            else if (state_q == ssl_pkg::ST_TX_WAIT && !wait_end)
                wait_q <= wait_q - 32'd1;
            else if (state_q == ssl_pkg::ST_TX_WAIT)
                rrq_q <= 1'b1;
            if (state_q == ssl_pkg::ST_IDLE && srq_rise)
                dma_transfer_count_q <= 8'(ssl_pkg::DMA_COUNT);
            if (wr_txd)
            begin
                tx_data_reg_q       <= reg_wdata_i;
                tx_reg_empty_flag_q <= 1'b0;
            end
            else if (load)
                tx_reg_empty_flag_q <= 1'b1;
            else if (dma_fetch_q)
            begin
                tx_data_reg_q        <= tbl_rdata;
                tx_reg_empty_flag_q  <= 1'b0;
                dma_transfer_count_q <= dma_transfer_count_q - 8'h01;
            end
            dma_fetch_q <= tx_dma;
            if (tx_dma)
                dma_memory_address_q <= dma_memory_address_q + 1'b1;
            // a landing byte wins over a software clear
            if (rx_mode && sh_done)
            begin
                rx_data_reg_q      <= sh_rx;
                rx_reg_full_flag_q <= 1'b1;
            end
            else if (rx_arm)
                rx_reg_full_flag_q <= 1'b0;
            else if (rx_store)
            begin
                rx_reg_full_flag_q <= 1'b0;
                dma_memory_address_q <= dma_memory_address_q + 1'b1;
                if (!last_rx)
                    dma_transfer_count_q <= dma_transfer_count_q - 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    logic [7:0] rd_mux;
    always_comb
    begin
        case (reg_addr_i)
            ssl_pkg::OFF_STATUS:  rd_mux = {3'h0, status_q};
            ssl_pkg::OFF_MASK:    rd_mux = {3'h0, mask_q};
            ssl_pkg::OFF_TXDATA:  rd_mux = tx_data_reg_q;
            ssl_pkg::OFF_RXDATA:  rd_mux = rx_data_reg_q;
            ssl_pkg::OFF_BITRATE: rd_mux = bitrate_q;
            ssl_pkg::OFF_COUNT:   rd_mux = dma_transfer_count_q;
            ssl_pkg::OFF_MEMADDR: rd_mux = 8'(dma_memory_address_q);
            ssl_pkg::OFF_STATE:   rd_mux = {3'h0, rx_reg_full_flag_q,
                                            tx_reg_empty_flag_q, 3'(state_q)};
            default:              rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o           <= 8'h00;
            sck_o                 <= 1'b1;
            sck_oe_o              <= 1'b0;
            txd_o                 <= 1'b1;
            receive_request_out_o <= 1'b1;
            irq_o                 <= 1'b0;
        end
        else
        begin
            reg_rdata_o           <= reg_rd_i ? rd_mux : 8'h00;
            sck_o                 <= sck_int;
            sck_oe_o              <= tx_mode;
            txd_o                 <= txd_int;
            receive_request_out_o <= rrq_q;
            irq_o                 <= |(status_q & mask_q);
        end
    end
endmodule : ssl_link

// [logic/ssl_pkg.sv]
// package of constants and types for the synchronous serial dma link
package ssl_pkg;

    // register offsets (word index on the plain register port)
    localparam logic [3:0] OFF_CTRL    = 4'h0;
    localparam logic [3:0] OFF_STATUS  = 4'h1;
    localparam logic [3:0] OFF_MASK    = 4'h2;
    localparam logic [3:0] OFF_TXDATA  = 4'h3;
    localparam logic [3:0] OFF_RXDATA  = 4'h4;
    localparam logic [3:0] OFF_BITRATE = 4'h5;
    localparam logic [3:0] OFF_COUNT   = 4'h6;
    localparam logic [3:0] OFF_MEMADDR = 4'h7;
    localparam logic [3:0] OFF_STATE   = 4'h8;
    localparam logic [3:0] OFF_TABLE   = 4'h9;

    // control bits
    localparam int CTL_TX_START = 0;
    localparam int CTL_RX_ARM   = 1;
    localparam int CTL_ABORT    = 2;

    // status / mask bits
    localparam int ST_TX_DONE  = 0;
    localparam int ST_RX_DONE  = 1;
    localparam int ST_TX_ERR   = 2;
    localparam int ST_RX_ERR   = 3;
    localparam int ST_EXT_EXTERNAL_IRQ_ZERO = 4;
    localparam int ST_W        = 5;

    // reset values
    localparam logic [7:0]      BITRATE_RST = 8'h01;
    localparam logic [ST_W-1:0] MASK_RST    = 5'h00;

    // timing
    localparam int CLK_HZ        = 40_000_000;
    localparam int REQ_DELAY_US  = 100;
    localparam int REQ_DELAY_CYC = REQ_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int BLOCK_BYTES   = 100;
    localparam int DMA_COUNT     = 99;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_TX_WAIT = 3'b001,
        ST_TX_RUN  = 3'b011,
        ST_RX_RUN  = 3'b010,
        ST_RX_WAIT = 3'b110
    } ssl_state_e;

    typedef struct packed {
        logic       clk_out;
        logic       clk_oe;
        logic       txd;
        logic       receive_request_out;
    } ssl_pins_s;

endpackage : ssl_pkg

// [logic/ssl_table_ram.sv]
// byte table memory with registered read data
`timescale 1ns/1ps
module ssl_table_ram #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          clock_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [7:0]    wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [7:0]    rdata_o
);
    logic [7:0] mem_q [DEPTH];

    always_ff @(posedge clock_i)
    begin
        if (we_i)
            mem_q[waddr_i] <= wdata_i;
        rdata_o <= mem_q[raddr_i];
    end
endmodule : ssl_table_ram

// [logic/ssl_shifter.sv]
// eight bit lsb-first synchronous shifter, master or slave clock
`timescale 1ns/1ps
module ssl_shifter (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       bit_en_i,
    input  wire logic       tx_mode_i,
    input  wire logic       rx_mode_i,
    input  wire logic       load_i,
    input  wire logic [7:0] load_data_i,
    input  wire logic       sck_i,
    input  wire logic       rxd_i,
    output logic            sck_o,
    output logic            txd_o,
    output logic            busy_o,
    output logic            byte_done_o,
    output logic [7:0]      rx_byte_o
);
    logic [7:0] sh_q;
    logic [3:0] cnt_q;
    logic       sck_prev_q;
    logic       rx_rise;

    assign rx_rise = rx_mode_i && sck_i && !sck_prev_q;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            sh_q        <= 8'h00;
            cnt_q       <= 4'h0;
            sck_o       <= 1'b1;
            txd_o       <= 1'b1;
            busy_o      <= 1'b0;
            byte_done_o <= 1'b0;
            rx_byte_o   <= 8'h00;
            sck_prev_q  <= 1'b1;
        end
        else
        begin
            byte_done_o <= 1'b0;
            sck_prev_q  <= sck_i;
            if (tx_mode_i)
            begin
                if (load_i && !busy_o)
                begin
                    sh_q   <= load_data_i;
                    cnt_q  <= 4'h0;
                    busy_o <= 1'b1;
                end
                else if (busy_o && bit_en_i)
                begin
                    // low half drives data, rising half lets slave sample
                    if (sck_o)
                    begin
                        sck_o <= 1'b0;
                        txd_o <= sh_q[0];
                    end
                    else
                    begin
                        sck_o <= 1'b1;
                        sh_q  <= {1'b0, sh_q[7:1]};
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == 4'h7)
                        begin
                            busy_o      <= 1'b0;
                            byte_done_o <= 1'b1;
                        end
                    end
                end
            end
            else
            begin
                sck_o  <= 1'b1;
                busy_o <= 1'b0;
                // data line idles high outside a transmit block
                txd_o  <= 1'b1;
                if (rx_rise)
                begin
                    sh_q  <= {rxd_i, sh_q[7:1]};
                    cnt_q <= (cnt_q == 4'h7) ? 4'h0 : cnt_q + 4'h1;
                    if (cnt_q == 4'h7)
                    begin
                        rx_byte_o   <= {rxd_i, sh_q[7:1]};
                        byte_done_o <= 1'b1;
                    end
                end
                else if (!rx_mode_i)
                    cnt_q <= 4'h0;
            end
        end
    end
endmodule : ssl_shifter

// [testbench/ssl_link_properties.sv]
// port checker for the serial link top
`timescale 1ns/1ps
module ssl_link_checker #(
    parameter int REQ_DELAY = ssl_pkg::REQ_DELAY_CYC
) (
    input wire logic       clock_i,
    input wire logic       rst_n_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       sck_o,
    input wire logic       sck_oe_o,
    input wire logic       txd_o,
    input wire logic       receive_request_out_o,
    input wire logic       send_request_in_i
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    int low_cnt_q;
    int low_cnt_d;
    assign low_cnt_d = receive_request_out_o ? 0 : low_cnt_q + 1;
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            low_cnt_q <= 0;
        else
            low_cnt_q <= low_cnt_d;
    end

    rrq_width_a: assert property (
        $rose(receive_request_out_o) |-> low_cnt_q == REQ_DELAY)
        else $error("request low time wrong");
    clk_start_a: assert property (
        $rose(receive_request_out_o) |-> ##[0:8] sck_oe_o)
        else $error("clock did not start after request");
    no_clk_req_a: assert property (
        !receive_request_out_o |-> !sck_oe_o)
        else $error("clock driven during request");
    rx_no_drive_a: assert property (
        send_request_in_i |-> !sck_oe_o)
        else $error("clock driven while far side sends");
    sck_idle_a: assert property (
        !sck_oe_o |-> sck_o)
        else $error("clock not idle high");
    txd_on_fall_a: assert property (
        sck_oe_o && $past(sck_oe_o) && $changed(txd_o) |-> $fell(sck_o))
        else $error("data changed off falling clock");
    txd_idle_a: assert property (
        !sck_oe_o && !$past(sck_oe_o) |-> txd_o)
        else $error("data line not idle high");
    half_bit_a: assert property (
        $fell(sck_o) |=> !sck_o ##1 sck_o)
        else $error("half bit length wrong");
    rdata_idle_a: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside read cycle");

    cover property ($rose(receive_request_out_o));
    cover property ($rose(send_request_in_i));
    cover property ($fell(sck_oe_o));
endmodule : ssl_link_checker

bind ssl_link ssl_link_checker #(.REQ_DELAY(REQ_DELAY)) chk_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .txd_o(txd_o),
    .receive_request_out_o(receive_request_out_o),
    .send_request_in_i(send_request_in_i));

// [testbench/ssl_peer_model.sv]
// far side controller: slave receiver and clock master sender
`timescale 1ns/1ps
module ssl_peer_model #(
    parameter int DELAY = 40,
    parameter int HALF  = 4
) (
    input  wire logic clock_i,
    input  wire logic sck_i,
    input  wire logic sck_oe_i,
    input  wire logic txd_i,
    output logic      sck_o,
    output logic      rxd_o,
    output logic      srq_o
);
    logic [7:0] sh_q   = 8'h00;
    logic       prev_q = 1'b1;
    logic       busy   = 1'b0;
    int         nbits  = 0;
    logic [7:0] got_q[$];

    initial
    begin
        sck_o = 1'b1;
        rxd_o = 1'b0;
        srq_o = 1'b0;
    end

    // sample on rising device clock, lsb first
    always @(posedge clock_i)
    begin
        prev_q <= sck_i;
        if (sck_oe_i && sck_i && !prev_q)
        begin
            sh_q = {txd_i, sh_q[7:1]};
            nbits = nbits + 1;
            if (nbits == 8)
            begin
                got_q.push_back(sh_q);
                nbits = 0;
            end
        end
    end

    // released data line keeps moving
    always @(posedge clock_i)
        if (!busy) rxd_o <= ~rxd_o;

    task automatic send_block(input logic [7:0] data[$]);
        busy = 1'b1;
        @(posedge clock_i);
        srq_o <= 1'b1;
        repeat (DELAY) @(posedge clock_i);
        foreach (data[i])
        begin
            for (int b = 0; b < 8; b++)
            begin
                sck_o <= 1'b0;
                rxd_o <= data[i][b];
                repeat (HALF) @(posedge clock_i);
                sck_o <= 1'b1;
                repeat (HALF) @(posedge clock_i);
            end
        end
        srq_o <= 1'b0;
        busy = 1'b0;
    endtask : send_block
endmodule : ssl_peer_model

// [testbench/ssl_link_tb_top.sv]
// self-checking bench: block transfers both ways through the link
`timescale 1ns/1ps
module ssl_link_tb_top;
    localparam int REQ_DELAY = 40;
    localparam int N         = ssl_pkg::BLOCK_BYTES;
    logic        clock_i     = 1'b0;
    logic        rst_n_i     = 1'b0;
    logic [3:0]  reg_addr_i  = 4'h0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic [7:0]  reg_rdata_o;
    logic        sck_i, sck_o, sck_oe_o, txd_o, rxd_i, rrq_n, send_request_in, irq_o;
    int          fails       = 0;
    int          checks      = 0;
    logic [15:0] lfsr        = 16'h26a5;
    logic [7:0]  tx_q[$];
    logic [7:0]  rx_q[$];

    always #12.5 clock_i = ~clock_i;

    ssl_link #(.REQ_DELAY(REQ_DELAY), .AW(8)) dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sck_i(sck_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
        .txd_o(txd_o), .rxd_i(rxd_i), .receive_request_out_o(rrq_n),
        .send_request_in_i(send_request_in), .irq_o(irq_o));

    ssl_peer_model #(.DELAY(REQ_DELAY), .HALF(4)) peer_u (
        .clock_i(clock_i), .sck_i(sck_o), .sck_oe_i(sck_oe_o), .txd_i(txd_o),
        .sck_o(sck_i), .rxd_o(rxd_i), .srq_o(send_request_in));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_byte

    task automatic cmp_pin(input logic got, input logic exp, input string what);
        cmp_byte({7'h00, got}, {7'h00, exp}, what);
    endtask : cmp_pin

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd_reg

    task automatic rd_cmp(input logic [3:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd_reg(a, d);
        cmp_byte(d, exp, what);
    endtask : rd_cmp

    task automatic wait_status(input int bitn, input int limit);
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < limit && !d[bitn]; i++)
            rd_reg(ssl_pkg::OFF_STATUS, d);
    endtask : wait_status

    task automatic irq_after(input logic exp, input string what);
        repeat (2) @(posedge clock_i);
        #1 cmp_pin(irq_o, exp, what);
    endtask : irq_after

    task automatic tx_block(input logic [7:0] base, input logic [7:0] data[$]);
        peer_u.got_q.delete();
        wr(ssl_pkg::OFF_MEMADDR, base + 8'h01);
        wr(ssl_pkg::OFF_TXDATA, data[0]);
        wr(ssl_pkg::OFF_CTRL, 8'h01);
        repeat (2) @(posedge clock_i);
        #1 cmp_pin(rrq_n, 1'b0, "request asserted");
        rd_cmp(ssl_pkg::OFF_COUNT, 8'h63, "dma count loaded");
        wait_status(ssl_pkg::ST_TX_DONE, 4000);
        repeat (100) @(posedge clock_i);
        cmp_pin(txd_o, 1'b1, "data line idle");
        cmp_pin(sck_oe_o, 1'b0, "clock released after block");
        rd_cmp(ssl_pkg::OFF_STATUS, 8'h01, "tx done");
        rd_cmp(ssl_pkg::OFF_MEMADDR, base + 8'h64, "address advanced");
        cmp_byte(8'(peer_u.got_q.size()), 8'h64, "bytes sent");
        foreach (data[i])
            cmp_byte(peer_u.got_q[i], data[i], "tx byte");
    endtask : tx_block

    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (40000) @(posedge clock_i);
        fails++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        results();
    end

    initial
    begin
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd_cmp(ssl_pkg::OFF_BITRATE, ssl_pkg::BITRATE_RST, "bitrate reset");
        rd_cmp(ssl_pkg::OFF_MASK, {3'h0, ssl_pkg::MASK_RST}, "mask reset");
        rd_cmp(4'hf, 8'h00, "unmapped read");
        cmp_pin(sck_oe_o, 1'b0, "clock released");
        cmp_pin(rrq_n, 1'b1, "request idle");
        $display("test reset done");
        wr(ssl_pkg::OFF_COUNT, 8'h00);
        for (int i = 0; i < N; i++)
        begin
            tx_q.push_back(lfsr[7:0]);
            lfsr = lfsr_next(lfsr);
            wr(ssl_pkg::OFF_TABLE, tx_q[i]);
        end
        tx_block(8'h00, tx_q);
        cmp_pin(irq_o, 1'b0, "done masked");
        wr(ssl_pkg::OFF_MASK, 8'h01);
        irq_after(1'b1, "done unmasked");
        wr(ssl_pkg::OFF_STATUS, 8'h1f);
        irq_after(1'b0, "done cleared");
        rd_cmp(ssl_pkg::OFF_STATUS, 8'h00, "status cleared");
        $display("test transmit done");
        for (int i = 0; i < N; i++)
        begin
            rx_q.push_back(lfsr[7:0]);
            lfsr = lfsr_next(lfsr);
        end
        wr(ssl_pkg::OFF_MASK, 8'h10);
        wr(ssl_pkg::OFF_MEMADDR, 8'h64);
        fork
            peer_u.send_block(rx_q);
            begin
                for (int i = 0; i < 200 && irq_o !== 1'b1; i++)
                    @(posedge clock_i) #1;
                cmp_pin(irq_o, 1'b1, "send request interrupt");
                wr(ssl_pkg::OFF_CTRL, 8'h02);
                wr(ssl_pkg::OFF_STATUS, 8'h10);
                wr(ssl_pkg::OFF_CTRL, 8'h01);
                irq_after(1'b0, "request cleared");
                cmp_pin(rrq_n, 1'b1, "no request in receive");
            end
        join
        wait_status(ssl_pkg::ST_RX_DONE, 200);
        rd_cmp(ssl_pkg::OFF_STATUS, 8'h06, "rx done, tx refused");
        rd_cmp(ssl_pkg::OFF_RXDATA, rx_q[N-1], "last byte");
        rd_cmp(ssl_pkg::OFF_MEMADDR, 8'hc8, "rx address advanced");
        wr(ssl_pkg::OFF_STATUS, 8'h1f);
        $display("test receive done");
        tx_block(8'h64, rx_q);
        $display("test echo done");
        results();
    end
endmodule : ssl_link_tb_top
